// file: core/fab_pkg.sv
// package: constants, register map and types of the burst acquisition block
// What this block does
// - converters sample continuously at fixed 50MHz, independent of processor
// - with ALL8 set while a burst runs, per-channel rate halves to 25MHz
// - eight channels, each result is a 14-bit sample
// - latest result per channel held, readable any time
// - single burst stores preset count of sets then stops itself
// - continuous burst keeps storing circularly until processor stops it
// - optional average over 2..31 fresh samples per averaged value
// - every channel compared against own upper and lower limit
// - burst memory readable at any time, even while burst writes
// - burst memory depth up to 134217728 values total
// - event-controlled burst stores exactly one set per event pulse
// - optional time channel stores free-running timer per event
// - three event inputs combined into one event by configurable scheme
// - 16-bit variant clocks converters every PERIOD+1 hclk cycles (13 at reset, about 3.85MHz), or once per event
// - 16-bit variant applies software gain 1, 2, 4 or 8
// - 16-bit variant converts all channels together, timer or event
// - running max and min per channel, readable and resettable
// - 16-bit variant has burst only from revision E04 on
package fab_pkg;
  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] FAB_CTRL     = 12'h000;
  localparam logic [11:0] FAB_STATUS   = 12'h004;
  localparam logic [11:0] FAB_COUNT    = 12'h008;
  localparam logic [11:0] FAB_WPTR     = 12'h00C;
  localparam logic [11:0] FAB_RPTR     = 12'h010;
  localparam logic [11:0] FAB_RDATA    = 12'h014;
  localparam logic [11:0] FAB_EVCFG    = 12'h018;
  localparam logic [11:0] FAB_PERIOD   = 12'h01C;
  localparam logic [11:0] FAB_LIMFLAG  = 12'h020;
  localparam logic [11:0] FAB_MMRESET  = 12'h024;
  localparam logic [11:0] FAB_TIMER    = 12'h028;
  localparam logic [11:0] FAB_SAMPLE0  = 12'h100;
  localparam logic [11:0] FAB_LIMIT0   = 12'h200;
  localparam logic [11:0] FAB_MINMAX0  = 12'h300;
  // ctrl fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_MODE   = 2;
  localparam int CTRL_EVENT  = 4;
  localparam int CTRL_TCHAN  = 5;
  localparam int CTRL_ALL8   = 6;
  localparam int CTRL_AVGEN  = 7;
  localparam int CTRL_AVGN   = 8;
  localparam int CTRL_WIDE   = 16;
  localparam int CTRL_GAIN   = 17;
  localparam int CTRL_PERTRG = 19;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [4:0]  AVG_MIN    = 5'h02;
  localparam logic [15:0] PERIOD_RESET = 16'h000C;
  // timing: converter rates as printed, divided against hclk
  localparam int HCLK_MHZ      = 50;
  localparam int SAMPLE_MHZ    = 50;
  localparam int SAMPLE8_MHZ   = 25;
  localparam int WIDE_MHZ      = 4;
  localparam int SAMPLE_DIV    = HCLK_MHZ / SAMPLE_MHZ;
  localparam int SAMPLE8_DIV   = HCLK_MHZ / SAMPLE8_MHZ;
  localparam int WIDE_DIV      = (HCLK_MHZ + WIDE_MHZ - 1) / WIDE_MHZ;

  typedef enum logic [1:0] {
    FAB_MODE_SINGLE = 2'h0,
    FAB_MODE_BURST  = 2'h1,
    FAB_MODE_CONT   = 2'h3
  } fab_mode_e;

  typedef enum logic [1:0] {
    FAB_IDLE = 2'h0,
    FAB_RUN  = 2'h1,
    FAB_DONE = 2'h3
  } fab_state_e;

  typedef struct packed {
    logic        primary;
    logic        secondary;
    logic        gate;
  } fab_event_s;
endpackage

// file: core/fab_top.sv
// burst acquisition control: converters, averaging, limits, burst memory
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
module fab_top #(
  parameter int CH        = 8,
  parameter int RES       = 14,
  parameter int MEM_AW    = 10,
  parameter int MEM_FULL_AW = 27,
  parameter logic [7:0] HW_REV = 8'h04
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [CH*16-1:0]  conv_data,
  input  wire fab_pkg::fab_event_s ev_in,
  output logic                   conv_strobe,
  output logic [1:0]             gain_sel
);
  import fab_pkg::*;

  localparam int DEPTH = 1 << MEM_AW;

  // ***************************************************************
  // bus slave: zero wait state, always OKAY
  // ***************************************************************
  logic        wr_pend_q, wr_pend_d;
  logic [11:0] wa_q, wa_d;
  logic [31:0] rdat_q, rdat_d;
  logic        acc;
  logic        wr;
  logic [11:0] ra;
  assign acc = hsel & htrans[1] & hready;
  assign ra  = haddr[11:0];
  assign wr  = wr_pend_q;

  // ***************************************************************
  // control state
  // ***************************************************************
  logic [31:0]       ctrl_q, ctrl_d;
  logic [31:0]       count_q, count_d;
  logic [15:0]       period_q, period_d;
  logic [3:0]        evcfg_q, evcfg_d;
  logic [MEM_AW-1:0] rptr_q, rptr_d;
  logic [MEM_AW-1:0] wptr_q, wptr_d;
  logic [31:0]       done_q, done_d;
  logic              ovf_q, ovf_d;
  logic [31:0]       timer_q;
  logic [CH-1:0]     limflag_q, limflag_d;
  fab_state_e        st_q, st_d;
  logic [3:0]        div_q, div_d;
  logic              ev_q;
  logic [31:0]       mem [DEPTH];
  logic [RES-1:0]    samp_q [CH];
  logic [RES-1:0]    mx_q [CH];
  logic [RES-1:0]    mn_q [CH];
  logic [RES-1:0]    hi_q [CH];
  logic [RES-1:0]    lo_q [CH];
  logic [RES+4:0]    acc_q [CH];
  logic [4:0]        avg_cnt_q, avg_cnt_d;

  fab_mode_e         mode;
  logic              wide;
  logic              tick;
  logic              ev_res;
  logic              ev_rise;
  logic              set_done;
  logic              mm_clr;
  logic [4:0]        avg_n;
  logic [3:0]        div_lim;
  logic [RES-1:0]    raw [CH];
  logic [CH-1:0]     lim_hit;
  logic              store;

  assign mode  = fab_mode_e'(ctrl_q[CTRL_MODE +: 2]);
  assign wide  = ctrl_q[CTRL_WIDE];
  assign avg_n = (ctrl_q[CTRL_AVGN +: 5] < AVG_MIN) ?
                 AVG_MIN : ctrl_q[CTRL_AVGN +: 5];
  assign mm_clr = wr && wa_q == FAB_MMRESET;

  // ***************************************************************
  // sample pacing and event combine
  // ***************************************************************
  always_comb begin
    if (wide)
      div_lim = 4'(WIDE_DIV - 1);
    else if (ctrl_q[CTRL_ALL8] && st_q == FAB_RUN)
      div_lim = 4'(SAMPLE8_DIV - 1);
    else
      div_lim = 4'(SAMPLE_DIV - 1);
    div_d = (div_q >= div_lim) ? 4'h0 : div_q + 4'h1;
  end
  assign tick = (div_q >= div_lim);

  // event scheme: bit0 use secondary, bit1 and/or, bit2 gate, bit3 invert
  always_comb begin
    logic p;
    p = ev_in.primary;
    if (evcfg_q[0])
      p = evcfg_q[1] ? (p & ev_in.secondary) : (p | ev_in.secondary);
    if (evcfg_q[2])
      p = p & ev_in.gate;
    ev_res = p ^ evcfg_q[3];
  end
  assign ev_rise = ev_res & ~ev_q;

  // ***************************************************************
  // converter front: raw sample, gain, average, limits
  // ***************************************************************
  logic conv_go;
  logic per_hit;
  logic [15:0] per_cnt_q, per_cnt_d;
  assign per_hit = per_cnt_q >= period_q;
  assign per_cnt_d = per_hit ? 16'h0000 : per_cnt_q + 16'h0001;
  // wide variant: one simultaneous conversion per trigger
  assign conv_go = wide ? (ctrl_q[CTRL_PERTRG] ? per_hit : ev_rise)
                        : tick;

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      raw[i] = conv_data[i*16 +: RES];
      lim_hit[i] = (samp_q[i] > hi_q[i]) || (samp_q[i] < lo_q[i]);
    end
  end

  assign avg_cnt_d = !conv_go ? avg_cnt_q :
                     (avg_cnt_q + 5'h01 >= avg_n) ? 5'h00 :
                     avg_cnt_q + 5'h01;
  // each average restarts its accumulator: fresh sample set every time
  assign store = conv_go && (!ctrl_q[CTRL_AVGEN] ||
                             avg_cnt_q + 5'h01 >= avg_n);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < CH; i++) begin
        samp_q[i] <= '0;
        acc_q[i]  <= '0;
        mx_q[i]   <= '0;
        mn_q[i]   <= '1;
        hi_q[i]   <= '1;
        lo_q[i]   <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < CH; i++) begin
        if (conv_go) begin
          if (store) begin
            if (ctrl_q[CTRL_AVGEN])
              samp_q[i] <= RES'((acc_q[i] + (RES+5)'(raw[i]))
                                / (RES+5)'(avg_n));
            else
              samp_q[i] <= raw[i];
            acc_q[i] <= '0;
          end else begin
            acc_q[i] <= acc_q[i] + (RES+5)'(raw[i]);
          end
        end
        if (mm_clr) begin
          mx_q[i] <= '0;
          mn_q[i] <= '1;
        end else begin
          if (samp_q[i] > mx_q[i]) mx_q[i] <= samp_q[i];
          if (samp_q[i] < mn_q[i]) mn_q[i] <= samp_q[i];
        end
        if (wr && wa_q == FAB_LIMIT0 + 12'(4*i)) begin
          hi_q[i] <= hwdata[16 +: RES];
          lo_q[i] <= hwdata[0 +: RES];
        end
      end
    end
  end

  // ***************************************************************
  // burst sequencer and memory
  // ***************************************************************
  logic burst_ok;
  logic [31:0] wword;
  assign burst_ok = !wide || HW_REV >= 8'h04;
  assign set_done = (st_q == FAB_RUN) &&
                    (ctrl_q[CTRL_EVENT] ? ev_rise : store);
  always_comb begin
    wword = '0;
    if (ctrl_q[CTRL_TCHAN] && ctrl_q[CTRL_EVENT])
      wword = timer_q;
    else
      for (int i = 0; i < 2 && i < CH; i++)
        wword[i*16 +: RES] = samp_q[i];
  end

  always_comb begin
    st_d   = st_q;
    wptr_d = wptr_q;
    done_d = done_q;
    ovf_d  = ovf_q;
    if (wr && wa_q == FAB_STATUS && hwdata[0])
      ovf_d = 1'b0;
    unique case (st_q)
      FAB_IDLE: begin
        if (wr && wa_q == FAB_CTRL && hwdata[CTRL_START] && burst_ok &&
            hwdata[CTRL_MODE +: 2] != FAB_MODE_SINGLE) begin
          st_d   = FAB_RUN;
          wptr_d = '0;
          done_d = '0;
        end
      end
      FAB_RUN: begin
        if (set_done) begin
          wptr_d = wptr_q + 1'b1;
          done_d = done_q + 32'h1;
          if (mode == FAB_MODE_CONT && wptr_q + 1'b1 == rptr_q)
            ovf_d = 1'b1;
          if (mode == FAB_MODE_BURST && done_q + 32'h1 >= count_q)
            st_d = FAB_DONE;
        end
        if (wr && wa_q == FAB_CTRL && hwdata[CTRL_STOP])
          st_d = FAB_DONE;
      end
      FAB_DONE: begin
        if (wr && wa_q == FAB_CTRL && hwdata[CTRL_START])
          st_d = FAB_IDLE;
      end
      default: st_d = FAB_IDLE;
    endcase
  end

  always_ff @(posedge hclk) begin
    if (clk_en && set_done)
      mem[wptr_q] <= wword;
  end

  // ***************************************************************
  // register writes and read mux
  // ***************************************************************
  always_comb begin
    wr_pend_d = acc & hwrite;
    wa_d      = ra;
    ctrl_d    = ctrl_q;
    count_d   = count_q;
    period_d  = period_q;
    evcfg_d   = evcfg_q;
    rptr_d    = rptr_q;
    limflag_d = limflag_q;
    if (wr) begin
      unique case (wa_q)
        FAB_CTRL:    ctrl_d   = hwdata & ~32'h0000_0003;
        FAB_COUNT:   count_d  = hwdata;
        FAB_PERIOD:  period_d = hwdata[15:0];
        FAB_EVCFG:   evcfg_d  = hwdata[3:0];
        FAB_RPTR:    rptr_d   = hwdata[MEM_AW-1:0];
        FAB_LIMFLAG: limflag_d = limflag_q & ~hwdata[CH-1:0];
        default: ;
      endcase
    end
    // pop side of block reads: read data advances the pointer
    if (acc && !hwrite && ra == FAB_RDATA)
      rptr_d = rptr_q + 1'b1;
    limflag_d = limflag_d | lim_hit;
    rdat_d = '0;
    if (acc && !hwrite) begin
      unique case (ra)
        FAB_CTRL:    rdat_d = ctrl_q;
        FAB_STATUS:  rdat_d = {29'h0, st_q, ovf_q};
        FAB_COUNT:   rdat_d = done_q;
        FAB_WPTR:    rdat_d = 32'(wptr_q);
        FAB_RPTR:    rdat_d = 32'(rptr_q);
        FAB_RDATA:   rdat_d = mem[rptr_q];
        FAB_EVCFG:   rdat_d = {28'h0, evcfg_q};
        FAB_PERIOD:  rdat_d = {16'h0, period_q};
        FAB_LIMFLAG: rdat_d = 32'(limflag_q);
        FAB_TIMER:   rdat_d = timer_q;
        default:
          for (int i = 0; i < CH; i++) begin
            if (ra == FAB_SAMPLE0 + 12'(4*i))
              rdat_d = 32'(samp_q[i]);
            if (ra == FAB_MINMAX0 + 12'(4*i))
              rdat_d = {2'h0, mx_q[i], 2'h0, mn_q[i]};
            if (ra == FAB_LIMIT0 + 12'(4*i))
              rdat_d = {2'h0, hi_q[i], 2'h0, lo_q[i]};
          end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q      <= '0;
      rdat_q    <= '0;
      ctrl_q    <= CTRL_RESET;
      count_q   <= '0;
      period_q  <= PERIOD_RESET;
      evcfg_q   <= '0;
      rptr_q    <= '0;
      wptr_q    <= '0;
      done_q    <= '0;
      ovf_q     <= 1'b0;
      timer_q   <= '0;
      limflag_q <= '0;
      st_q      <= FAB_IDLE;
      div_q     <= '0;
      ev_q      <= 1'b0;
      avg_cnt_q <= '0;
      per_cnt_q <= '0;
      conv_strobe <= 1'b0;
      gain_sel  <= 2'h0;
    end else if (clk_en) begin
      wr_pend_q <= wr_pend_d;
      wa_q      <= wa_d;
      rdat_q    <= rdat_d;
      ctrl_q    <= ctrl_d;
      count_q   <= count_d;
      period_q  <= period_d;
      evcfg_q   <= evcfg_d;
      rptr_q    <= rptr_d;
      wptr_q    <= wptr_d;
      done_q    <= done_d;
      ovf_q     <= ovf_d;
      timer_q   <= timer_q + 32'h1;
      limflag_q <= limflag_d;
      st_q      <= st_d;
      div_q     <= div_d;
      ev_q      <= ev_res;
      avg_cnt_q <= avg_cnt_d;
      per_cnt_q <= per_cnt_d;
      conv_strobe <= conv_go;
      gain_sel  <= wide ? ctrl_q[CTRL_GAIN +: 2] : 2'h0;
    end
  end

  assign hrdata    = rdat_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_single_stop;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && st_q == FAB_RUN && mode == FAB_MODE_BURST && set_done &&
     done_q + 32'h1 >= count_q && !wr) |=> st_q == FAB_DONE;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single burst did not stop at count");

  property p_wptr_adv;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && set_done) |=> wptr_q == $past(wptr_q) + 1'b1;
  endproperty
  a_wptr_adv: assert property (p_wptr_adv)
    else $error("write pointer did not advance on stored set");

  property p_limflag;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && lim_hit[0]) |=> limflag_q[0];
  endproperty
  a_limflag: assert property (p_limflag)
    else $error("limit flag not set on violation");

  property p_max;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && !mm_clr) |=> mx_q[0] >= $past(samp_q[0]);
  endproperty
  a_max: assert property (p_max)
    else $error("maximum below sample");

  property p_idle_nowrite;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && st_q == FAB_DONE) |=> $stable(wptr_q) && $stable(done_q);
  endproperty
  a_idle_nowrite: assert property (p_idle_nowrite)
    else $error("store outside burst");

  property p_rate;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && !wide && ctrl_q[CTRL_ALL8] && st_q == FAB_RUN && tick)
    |=> !(tick && st_q == FAB_RUN && ctrl_q[CTRL_ALL8]);
  endproperty
  a_rate: assert property (p_rate)
    else $error("eight-channel rate above half clock");

  property p_ovf;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && st_q == FAB_RUN && mode == FAB_MODE_CONT && set_done &&
     wptr_q + 1'b1 == rptr_q) |=> ovf_q;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");

  property p_gain;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wide) |=> gain_sel == $past(ctrl_q[CTRL_GAIN +: 2]);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain select mismatch");

  c_burst_done: cover property (@(posedge hclk) st_q == FAB_DONE);
  c_ovf: cover property (@(posedge hclk) ovf_q);
  c_event: cover property (@(posedge hclk) set_done && ctrl_q[CTRL_EVENT]);
endmodule

// file: testbench/fab_conv_model.sv
// converter front end model feeding the acquisition block
`timescale 1ns/10ps
module fab_conv_model #(
  parameter int CH = 8
) (
  input  wire logic              hclk,
  input  wire logic [13:0]       base,
  output logic [CH*16-1:0]       conv_data
);
  // ***************************************************************
  // staged results: channel i carries base + i
  // ***************************************************************
  logic [1:0] junk_q = 2'h0;

  always @(posedge hclk) begin
    junk_q <= ~junk_q;
  end

  // spare top bits toggle, so a lost 14-bit mask shows up
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      conv_data[i*16 +: 16] = {junk_q, 14'(base + 14'(i))};
    end
  end
endmodule

// file: testbench/fab_top_tb.sv
// self-checking bench for the burst acquisition block
`timescale 1ns/10ps
module fab_top_tb;
  import fab_pkg::*;
  // ***************************************************************
  // signals, instances, bus tasks
  // ***************************************************************
  logic         hclk;
  logic         hresetn;
  logic         clk_en;
  logic         hsel;
  logic         hwrite;
  logic [31:0]  haddr;
  logic [31:0]  hwdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic [127:0] conv_data;
  fab_event_s   ev_in;
  logic         conv_strobe;
  logic [1:0]   gain_sel;
  logic [13:0]  base;
  logic [31:0]  rd;
  logic [31:0]  w0;
  int           fails;
  int           tests_run;
  int           nstrobe = 0;

  fab_top u_fab_top (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_data(conv_data), .ev_in(ev_in), .conv_strobe(conv_strobe),
    .gain_sel(gain_sel));

  fab_conv_model u_fab_conv_model (.hclk(hclk), .base(base),
    .conv_data(conv_data));

  // conversions seen so far; updated late so task reads stay race free
  always @(posedge hclk) begin
    nstrobe <= nstrobe + int'(conv_strobe);
  end

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      chk("hready wait", 32'h1, 32'h0);
      close_out();
    end
  endtask

  // read data taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask

  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp & m, rd & m);
  endtask

  task automatic poll(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] exp, input int lim);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== exp && n < lim);
    if ((rd & m) !== exp) begin
      chk("poll timeout", exp, rd & m);
      close_out();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one rising edge every seven cycles, well under the event limit
  task automatic pulse();
    @(posedge hclk);
    ev_in.primary <= 1'b1;
    idle(2);
    ev_in.primary <= 1'b0;
    idle(4);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_regs();
    rdc("ctrl reset", FAB_CTRL, 32'hFFFFFFFF, CTRL_RESET);
    rdc("period reset", FAB_PERIOD, 32'hFFFF, {16'h0, PERIOD_RESET});
    rdc("state reset", FAB_STATUS, 32'h6, 32'h0);
    wr(12'h0F0, 32'hA5A5A5A5);
    rdc("unmapped", 12'h0F0, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_single();
    for (int k = 0; k < 2; k++) begin
      base <= (k == 0) ? 14'h1230 : 14'h2345;
      wr(FAB_CTRL, (k == 0) ? 32'h0 : (32'h1 << CTRL_AVGEN) |
         (32'h2 << CTRL_AVGN));
      idle(60);
      for (int i = 0; i < 8; i++) begin
        rdc("sample", FAB_SAMPLE0 + 12'(4*i), 32'hFFFFFFFF,
            {18'h0, 14'(base + 14'(i))});
      end
    end
    wr(FAB_CTRL, 32'h0);
  endtask

  task automatic t_limits();
    wr(FAB_LIMIT0, {2'h0, 14'h0100, 2'h0, 14'h0010});
    wr(FAB_LIMIT0 + 12'h4, {2'h0, 14'h3FFF, 2'h0, 14'h0000});
    base <= 14'h0050;
    idle(10);
    wr(FAB_LIMFLAG, 32'hFF);
    rdc("limflag clear", FAB_LIMFLAG, 32'h3, 32'h0);
    base <= 14'h0200;
    idle(10);
    rdc("limflag high", FAB_LIMFLAG, 32'h3, 32'h1);
    base <= 14'h0050;
    idle(10);
    rdc("limflag sticky", FAB_LIMFLAG, 32'h3, 32'h1);
    wr(FAB_LIMFLAG, 32'h1);
    rdc("limflag w1c", FAB_LIMFLAG, 32'h3, 32'h0);
    base <= 14'h0005;
    idle(10);
    rdc("limflag low", FAB_LIMFLAG, 32'h3, 32'h1);
  endtask

  task automatic t_minmax();
    base <= 14'h004E;
    idle(10);
    wr(FAB_MMRESET, 32'h1);
    idle(10);
    base <= 14'h002E;
    idle(10);
    base <= 14'h006E;
    idle(10);
    base <= 14'h004E;
    idle(10);
    rdc("minmax", FAB_MINMAX0 + 12'h8, 32'hFFFFFFFF,
        {2'h0, 14'h0070, 2'h0, 14'h0030});
  endtask

  task automatic t_burst();
    base <= 14'h0111;
    wr(FAB_COUNT, 32'h4);
    wr(FAB_CTRL, (32'(FAB_MODE_BURST) << CTRL_MODE) | 32'h1);
    poll(FAB_STATUS, 32'h6, 32'h6, 100);
    idle(20);
    rdc("sets stored", FAB_COUNT, 32'hFFFFFFFF, 32'h4);
    for (int i = 0; i < 4; i++) begin
      rdc("burst word", FAB_RDATA, 32'hFFFFFFFF,
          {2'h0, 14'h0112, 2'h0, 14'h0111});
    end
    rdc("read ptr", FAB_RPTR, 32'hFFFFFFFF, 32'h4);
  endtask

  task automatic to_idle();
    bus(1'b0, FAB_STATUS, 32'h0);
    if (rd[2:1] === 2'h3) begin
      wr(FAB_CTRL, 32'h1);
    end
    poll(FAB_STATUS, 32'h6, 32'h0, 20);
  endtask

  task automatic t_cont();
    to_idle();
    wr(FAB_COUNT, 32'h400);
    wr(FAB_CTRL, (32'(FAB_MODE_CONT) << CTRL_MODE) |
       (32'h1 << CTRL_ALL8) | 32'h1);
    poll(FAB_STATUS, 32'h6, 32'h2, 20);
    w0 = nstrobe;
    idle(20);
    chk("all8 conversions", 32'd10, nstrobe - w0);
    bus(1'b0, FAB_WPTR, 32'h0);
    w0 = rd;
    idle(5);
    bus(1'b0, FAB_WPTR, 32'h0);
    chk("wptr moves", 32'h1, {31'h0, w0 !== rd});
    poll(FAB_STATUS, 32'h1, 32'h1, 1500);
    wr(FAB_CTRL, (32'(FAB_MODE_CONT) << CTRL_MODE) | 32'h2);
    idle(5);
    bus(1'b0, FAB_WPTR, 32'h0);
    w0 = rd;
    idle(20);
    rdc("wptr stopped", FAB_WPTR, 32'hFFFFFFFF, w0);
    wr(FAB_STATUS, 32'h1);
    rdc("overflow w1c", FAB_STATUS, 32'h1, 32'h0);
  endtask

  task automatic t_event();
    to_idle();
    wr(FAB_EVCFG, 32'h4);
    wr(FAB_COUNT, 32'h3);
    wr(FAB_CTRL, (32'(FAB_MODE_BURST) << CTRL_MODE) |
       (32'h1 << CTRL_EVENT) | (32'h1 << CTRL_TCHAN) | 32'h1);
    repeat (2) pulse();
    idle(10);
    rdc("gated events", FAB_COUNT, 32'hFFFFFFFF, 32'h0);
    ev_in.gate <= 1'b1;
    idle(2);
    repeat (3) pulse();
    poll(FAB_STATUS, 32'h6, 32'h6, 40);
    rdc("event sets", FAB_COUNT, 32'hFFFFFFFF, 32'h3);
    // back to back pulses rise seven clocks apart
    wr(FAB_RPTR, 32'h0);
    bus(1'b0, FAB_RDATA, 32'h0);
    for (int i = 0; i < 2; i++) begin
      w0 = rd;
      bus(1'b0, FAB_RDATA, 32'h0);
      chk("time step", 32'd7, rd - w0);
    end
  endtask

  task automatic t_gain();
    wr(FAB_EVCFG, 32'hD);
    for (int g = 0; g < 4; g++) begin
      wr(FAB_CTRL, (32'h1 << CTRL_WIDE) | (32'(g) << CTRL_GAIN));
      idle(3);
      chk("gain", 32'(g), {30'h0, gain_sel});
    end
    wr(FAB_CTRL, 32'h1 << CTRL_WIDE);
    idle(3);
    w0 = nstrobe;
    repeat (2) pulse();
    idle(3);
    chk("event conversions", 32'h2, nstrobe - w0);
    wr(FAB_CTRL, 32'h0);
    idle(3);
    chk("gain narrow", 32'h0, {30'h0, gain_sel});
    w0 = nstrobe;
    idle(10);
    chk("free conversions", 32'd10, nstrobe - w0);
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    chk("run length", 32'h0, 32'h1);
    close_out();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    base = 14'h0;
    ev_in = '0;
    idle(6);
    chk("reset outputs", 32'h8, {28'h0, hreadyout, hresp,
        conv_strobe, |gain_sel});
    hresetn <= 1'b1;
    t_regs();
    t_single();
    t_limits();
    t_minmax();
    t_burst();
    t_cont();
    t_event();
    t_gain();
    close_out();
  end
endmodule
